/* File: rtl/eeprg_ctrl.sv */
// Data EEPROM erase and write control with AXI4-Lite registers
`default_nettype none
module eeprg_ctrl (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              clockEnable,
  // AXI4-Lite slave
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Array side
  output eeprg_pkg::eeprg_req_t  arrayReq,
  output logic                   arrayValid,
  input  wire logic              arrayDone,
  // Abort sources from outside the clock domain
  input  wire logic              externalResetPin,
  input  wire logic              watchdogTimerReset,
  output logic                   irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]                   ctrl_q;
  eeprg_pkg::eeprg_state_t       state_q;
  logic [3:0]                    awAddr_q;
  logic                          awHeld_q;
  logic [31:0]                   wData_q;
  logic [3:0]                    wStrb_q;
  logic                          wHeld_q;
  logic [1:0]                    sync1_q;
  logic [1:0]                    sync2_q;
  logic [eeprg_pkg::IRQ_W-1:0]   irqStatus_q;
  logic [eeprg_pkg::IRQ_W-1:0]   irqEnable_q;
  logic                          opValid;
  logic                          doWrite;
  logic                          ctrlWrite;
  logic [15:0]                   ctrlData;
  logic                          startReq;
  logic                          launch;
  logic                          reject;
  logic                          aborting;
  logic                          finish;
  logic [eeprg_pkg::IRQ_W-1:0]   irqEvents;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture, either order
  // Frozen slave must not accept, or the item would be lost
  assign s_axi_awready = clockEnable && !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = clockEnable && !wHeld_q && !s_axi_bvalid;
  assign doWrite       = awHeld_q && wHeld_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else if (clockEnable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= eeprg_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        if (awAddr_q == eeprg_pkg::ADDR_CTRL || awAddr_q == eeprg_pkg::ADDR_IRQ_CLEAR ||
            awAddr_q == eeprg_pkg::ADDR_IRQ_ENABLE || awAddr_q == eeprg_pkg::ADDR_IRQ_STATUS) begin
          s_axi_bresp <= eeprg_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= eeprg_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register write merge, byte lanes honoured
  assign ctrlWrite = doWrite && (awAddr_q == eeprg_pkg::ADDR_CTRL);
  always_comb begin
    ctrlData = ctrl_q;
    if (wStrb_q[0]) begin
      ctrlData[7:0] = wData_q[7:0];
    end
    if (wStrb_q[1]) begin
      ctrlData[15:8] = wData_q[15:8];
    end
  end
  assign startReq = ctrlWrite && wStrb_q[1] && wData_q[eeprg_pkg::BIT_START];
  // Enable may be set in the same write as start
  assign launch   = startReq && ctrlData[eeprg_pkg::BIT_ENABLE] && !ctrl_q[eeprg_pkg::BIT_START];
  assign reject   = startReq && !ctrlData[eeprg_pkg::BIT_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Abort sources, two-stage synchronisers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
    end else if (clockEnable) begin
      sync1_q <= {watchdogTimerReset, externalResetPin};
      sync2_q <= sync1_q;
    end
  end
  assign aborting = (state_q != eeprg_pkg::ST_IDLE) && (|sync2_q);
  assign finish   = (state_q == eeprg_pkg::ST_WRITE && arrayDone) ||
                    (state_q == eeprg_pkg::ST_ERASE && arrayDone && ctrl_q[eeprg_pkg::BIT_ERASE]);

  ////////////////////////////////////////////////////////////////////////////
  // Operation code decode
  always_comb begin
    opValid       = 1'b1;
    arrayReq      = '0;
    if (ctrl_q[eeprg_pkg::BIT_ERASE]) begin
      arrayReq.erase = 1'b1;
      case (ctrl_q[5:0])
        eeprg_pkg::OP_ERASE8: arrayReq.words = 4'h8;
        eeprg_pkg::OP_ERASE4: arrayReq.words = 4'h4;
        eeprg_pkg::OP_ERASE1: arrayReq.words = 4'h1;
        default:              opValid = 1'b0;
      endcase
    end else begin
      arrayReq.words = 4'h1;
      opValid        = (ctrl_q[5:0] == eeprg_pkg::OP_WRITE1);
      // Pre-erase phase unless skip-erase
      arrayReq.erase = (state_q == eeprg_pkg::ST_ERASE);
      arrayReq.write = (state_q == eeprg_pkg::ST_WRITE);
    end
  end
  assign arrayValid = (state_q != eeprg_pkg::ST_IDLE) && opValid;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer; an unknown code ends at once without touching the array
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= eeprg_pkg::ST_IDLE;
    end else if (clockEnable) begin
      case (state_q)
        eeprg_pkg::ST_IDLE: begin
          if (launch) begin
            if (ctrlData[eeprg_pkg::BIT_ERASE] || !ctrlData[eeprg_pkg::BIT_SKIP]) begin
              state_q <= eeprg_pkg::ST_ERASE;
            end else begin
              state_q <= eeprg_pkg::ST_WRITE;
            end
          end
        end
        eeprg_pkg::ST_ERASE: begin
          if (aborting || !opValid || finish) begin
            state_q <= eeprg_pkg::ST_IDLE;
          end else if (arrayDone) begin
            state_q <= eeprg_pkg::ST_WRITE;
          end
        end
        eeprg_pkg::ST_WRITE: begin
          if (aborting || !opValid || finish) begin
            state_q <= eeprg_pkg::ST_IDLE;
          end
        end
        default: state_q <= eeprg_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= eeprg_pkg::CTRL_RESET;
    end else if (clockEnable) begin
      if (state_q != eeprg_pkg::ST_IDLE && (aborting || !opValid || finish)) begin
        ctrl_q[eeprg_pkg::BIT_START]  <= 1'b0;
        ctrl_q[eeprg_pkg::BIT_ENABLE] <= 1'b0;
        ctrl_q[eeprg_pkg::BIT_ABORT]  <= aborting;
      end else if (ctrlWrite && state_q == eeprg_pkg::ST_IDLE) begin
        // Settings frozen while a cycle runs
        // Abort flag is read-only, kept across software writes
        ctrl_q <= (ctrlData & eeprg_pkg::CTRL_WMASK) |
                  {launch, 1'b0, ctrl_q[eeprg_pkg::BIT_ABORT], 13'h0000};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  assign irqEvents[eeprg_pkg::IRQ_DONE]   = (state_q != eeprg_pkg::ST_IDLE) && finish && !aborting;
  assign irqEvents[eeprg_pkg::IRQ_ABORT]  = aborting;
  assign irqEvents[eeprg_pkg::IRQ_REJECT] = reject;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_q <= '0;
      irqEnable_q <= '0;
    end else if (clockEnable) begin
      if (doWrite && awAddr_q == eeprg_pkg::ADDR_IRQ_CLEAR && wStrb_q[0]) begin
        irqStatus_q <= (irqStatus_q & ~wData_q[eeprg_pkg::IRQ_W-1:0]) | irqEvents;
      end else begin
        irqStatus_q <= irqStatus_q | irqEvents;
      end
      if (doWrite && awAddr_q == eeprg_pkg::ADDR_IRQ_ENABLE && wStrb_q[0]) begin
        irqEnable_q <= wData_q[eeprg_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqStatus_q & irqEnable_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready = clockEnable && !s_axi_rvalid;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= eeprg_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= eeprg_pkg::RESP_OKAY;
        if (s_axi_araddr == eeprg_pkg::ADDR_CTRL) begin
          s_axi_rdata <= {16'h0000, ctrl_q};
        end else if (s_axi_araddr == eeprg_pkg::ADDR_IRQ_STATUS) begin
          s_axi_rdata <= {29'h0, irqStatus_q};
        end else if (s_axi_araddr == eeprg_pkg::ADDR_IRQ_ENABLE) begin
          s_axi_rdata <= {29'h0, irqEnable_q};
        end else if (s_axi_araddr == eeprg_pkg::ADDR_IRQ_CLEAR) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= eeprg_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : eeprg_ctrl
`default_nettype wire

/* File: rtl/eeprg_pkg.sv */
// Shared constants and types for the data EEPROM program control block
`default_nettype none
package eeprg_pkg;
  // Register byte addresses
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_CLEAR  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'hC;
  // Control field positions
  localparam int          BIT_START       = 15;
  localparam int          BIT_ENABLE      = 14;
  localparam int          BIT_ABORT       = 13;
  localparam int          BIT_SKIP        = 12;
  localparam int          BIT_ERASE       = 6;
  // Writable control bits (start and abort flag handled apart)
  localparam logic [15:0] CTRL_WMASK      = 16'h507F;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  // Operation codes
  localparam logic [5:0]  OP_ERASE8       = 6'h1A;
  localparam logic [5:0]  OP_ERASE4       = 6'h19;
  localparam logic [5:0]  OP_ERASE1       = 6'h18;
  localparam logic [5:0]  OP_WRITE1       = 6'h04;
  // Interrupt status bits
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_ABORT       = 1;
  localparam int          IRQ_REJECT      = 2;
  localparam int          IRQ_W           = 3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10
  } eeprg_state_t;

  // Request to the array
  typedef struct packed {
    logic       erase;
    logic       write;
    logic [3:0] words;
  } eeprg_req_t;
endpackage : eeprg_pkg
`default_nettype wire

/* File: tb/eeprg_ctrl_props.sv */
// Port checker for the EEPROM program control block
`default_nettype none
module eeprg_ctrl_props (
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire logic                  clockEnable,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire eeprg_pkg::eeprg_req_t arrayReq,
  input wire logic                  arrayValid,
  input wire logic                  arrayDone,
  input wire logic                  externalResetPin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence eraseEnd; arrayValid && arrayReq.erase && arrayDone; endsequence
  sequence writeEnd; arrayValid && arrayReq.write && arrayDone; endsequence
  ////////////////////////////////////////
  a_phase_excl: assert property (arrayValid |-> !(arrayReq.erase && arrayReq.write))
    else $error("erase and write at once");
  a_word_count: assert property (arrayValid |-> arrayReq.words inside {4'h8, 4'h4, 4'h1})
    else $error("bad word count");
  a_write_one: assert property (arrayValid && arrayReq.write |-> arrayReq.words == 4'h1)
    else $error("write not one word");
  a_erase_next: assert property (eraseEnd |=> !arrayValid || arrayReq.write)
    else $error("bad phase after erase");
  a_write_last: assert property (writeEnd |=> !arrayValid)
    else $error("cycle runs past write");
  // Two sync stages, so allow up to three edges
  a_abort_ends: assert property ((arrayValid && externalResetPin && clockEnable) [*2] |-> ##[1:3] !arrayValid)
    else $error("abort did not end cycle");
  // Launch shares its edge with the write response, which stands until taken
  a_launch_write: assert property ($rose(arrayValid) |-> s_axi_bvalid)
    else $error("cycle without a write");
  a_clk_freeze: assert property (!clockEnable |=> $stable(arrayValid) && $stable(s_axi_bvalid))
    else $error("state moved while frozen");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clockEnable |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : eeprg_ctrl_props
bind eeprg_ctrl eeprg_ctrl_props u_props (.clock, .rst_b, .clockEnable, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .arrayReq, .arrayValid, .arrayDone, .externalResetPin);
`default_nettype wire

/* File: tb/eeprg_array_model.sv */
// Behavioural data EEPROM array answering each phase
`default_nettype none
module eeprg_array_model (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire eeprg_pkg::eeprg_req_t arrayReq,
  input  wire logic                  arrayValid,
  input  wire logic [7:0]            latency,
  output logic                       arrayDone,
  output int                         eraseCount,
  output int                         writeCount,
  output logic [3:0]                 lastWords
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] waitCnt_q;
  // Done is a single-cycle pulse, never held
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_q <= 8'h00;
      arrayDone <= 1'b0;
    end else if (!arrayValid || arrayDone) begin
      waitCnt_q <= 8'h00;
      arrayDone <= 1'b0;
    end else if (waitCnt_q >= latency) begin
      arrayDone <= 1'b1;
    end else begin
      waitCnt_q <= waitCnt_q + 8'h01;
    end
  end
  // Tally finished phases
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eraseCount <= 0;
      writeCount <= 0;
      lastWords <= 4'h0;
    end else if (arrayValid && arrayDone) begin
      eraseCount <= eraseCount + int'(arrayReq.erase);
      writeCount <= writeCount + int'(arrayReq.write);
      lastWords <= arrayReq.words;
    end
  end
endmodule : eeprg_array_model
`default_nettype wire

/* File: tb/eeprg_ctrl_test.sv */
// Register-level bench for the EEPROM program control block
`default_nettype none
module eeprg_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] C = eeprg_pkg::ADDR_CTRL;
  localparam logic [3:0] S = eeprg_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] K = eeprg_pkg::ADDR_IRQ_CLEAR;
  localparam logic [3:0] E = eeprg_pkg::ADDR_IRQ_ENABLE;
  localparam logic [1:0] OK = eeprg_pkg::RESP_OKAY;
  logic                  clock, rst_b, clockEnable, extPin, wdogPin, irq, arrayValid, arrayDone;
  logic                  awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [3:0]            awAddr, arAddr, wStrb, lastWords;
  logic [31:0]           wData, rData;
  logic [1:0]            bResp, rResp;
  logic [7:0]            latency;
  eeprg_pkg::eeprg_req_t arrayReq;
  int                    eraseCount, writeCount, mismatches, samplesChecked;
  logic [5:0]            ops [3] = '{eeprg_pkg::OP_ERASE8, eeprg_pkg::OP_ERASE4, eeprg_pkg::OP_ERASE1};
  logic [3:0]            wds [3] = '{4'h8, 4'h4, 4'h1};

  eeprg_ctrl dut (.clock, .rst_b, .clockEnable, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .arrayReq, .arrayValid,
    .arrayDone, .externalResetPin(extPin), .watchdogTimerReset(wdogPin), .irq);
  eeprg_array_model u_array (.clock, .rst_b, .arrayReq, .arrayValid, .latency, .arrayDone,
    .eraseCount, .writeCount, .lastWords);

  initial clock = 1'b0;
  always #25 clock = ~clock;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chkResp
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    awAddr <= a; wData <= d; wStrb <= s;
    awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    do begin
      @(posedge clock);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while ((awValid && !awReady) || (wValid && !wReady));
    do @(posedge clock); while (bValid !== 1'b1);
    bReady <= 1'b0;
    chkResp(bResp, OK);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do @(posedge clock); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clock); while (rValid !== 1'b1);
    d = rData; r = rResp;
    rReady <= 1'b0;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = OK,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
    chkResp(r, er);
  endtask : rc
  // Poll instead of a fixed wait: cycle length is the array's choice
  task automatic waitIdle();
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h8000;
    // A hang here is ended by the 20000-cycle timeout block
    while (d[15] !== 1'b0) rd(C, d, r);
  endtask : waitIdle
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    stop_test();
  end
  initial begin
    {rst_b, clockEnable, extPin, wdogPin, awValid, wValid, bReady, arValid, rReady} = '0;
    {awAddr, arAddr, wStrb, wData, latency} = '0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    clockEnable <= 1'b1;
    rc(C, 32'h0);
    rc(S, 32'h0);
    rc(4'h2, 32'h0, eeprg_pkg::RESP_SLVERR);
    wr(E, 32'h7, 4'h1);
    wr(C, 32'h8058, 4'h3);
    rc(C, 32'h0, OK, 32'h8000);
    rc(S, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(E, 32'h0, 4'h1);
    rc(S, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(E, 32'h7, 4'h1);
    wr(K, 32'h7, 4'h1);
    rc(S, 32'h0);
    chk({31'h0, irq}, 32'h0);
    latency <= 8'd40;
    for (int k = 0; k < 2; k++) begin
      wr(C, 32'hC05A, 4'h3);
      wr(C, 32'h0, 4'h3);
      rc(C, 32'h8000, OK, 32'h8000);
      if (k == 0) extPin <= 1'b1;
      else wdogPin <= 1'b1;
      repeat (5) @(posedge clock);
      {extPin, wdogPin} <= 2'b00;
      waitIdle();
      rc(C, 32'h2000, OK, 32'hA000);
      rc(S, 32'h2, OK, 32'h2);
      wr(K, 32'h7, 4'h1);
    end
    chk(eraseCount, 0);
    latency <= 8'd2;
    for (int i = 0; i < 3; i++) begin
      wr(C, 32'hCFC0 | {26'h0, ops[i]}, 4'h3);
      waitIdle();
      rc(C, 32'h40 | {26'h0, ops[i]});
      chk({28'h0, lastWords}, {28'h0, wds[i]});
      chk(eraseCount, i + 1);
      rc(S, 32'h1);
      wr(K, 32'h1, 4'h1);
    end
    latency <= 8'd0;
    wr(C, 32'hC000 | {26'h0, eeprg_pkg::OP_WRITE1}, 4'h3);
    waitIdle();
    chk(eraseCount, 4);
    chk(writeCount, 1);
    wr(C, 32'hD000 | {26'h0, eeprg_pkg::OP_WRITE1}, 4'h3);
    waitIdle();
    rc(C, 32'h1000 | {26'h0, eeprg_pkg::OP_WRITE1});
    chk(eraseCount, 4);
    chk(writeCount, 2);
    wr(C, 32'h207F, 4'h3);
    rc(C, 32'h7F);
    wr(K, 32'h7, 4'h1);
    wr(C, 32'hC07F, 4'h3);
    waitIdle();
    rc(C, 32'h7F);
    rc(S, 32'h0);
    chk(eraseCount, 4);
    chk(writeCount, 2);
    stop_test();
  end
endmodule : eeprg_ctrl_test
`default_nettype wire
